// ---- inc/pio_defines.svh ----
// constants of the programmable pin configuration block
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define PIO_OFS_MODE      12'h000
`define PIO_OFS_DIR       12'h004
`define PIO_OFS_PULL      12'h008
`define PIO_OFS_DOUT      12'h00C
`define PIO_OFS_PIN_IN    12'h010
`define PIO_OFS_LOWER_SEL 12'h014
`define PIO_OFS_UPPER_SEL 12'h018
`define PIO_OFS_STATUS    12'h01C

// ***************************************************************
// field positions
// ***************************************************************
`define PIO_DA_BIT        7
`define PIO_ST_STRAP_LOW  0
`define PIO_ST_SHORT_RST  1
`define PIO_ST_RUNNING    2

// ***************************************************************
// reset values, fixed pin masks and restart address
// ***************************************************************
`define PIO_MODE_RST      32'hFFFF_FC0F
`define PIO_DIR_RST       32'h0000_0000
`define PIO_PULL_RST      32'hFF3F_FBBD
`define PIO_DOUT_RST      32'h0000_0000
`define PIO_SEL_RST       16'h0000
`define PIO_PULLUP_ONLY   32'h0000_03B0
`define PIO_PULLDN_ONLY   32'h0000_0040
`define PIO_STRAP_LOCK    32'h2400_0000
`define PIO_RESTART_ADDR  20'hFFFF0

// ***************************************************************
// timing
// ***************************************************************
`define PIO_CLK_PERIOD_NS 40
`define PIO_RESET_MIN_NS  1000000
`define PIO_RESET_MIN_CYC (`PIO_RESET_MIN_NS / `PIO_CLK_PERIOD_NS)
`define PIO_STRAP_XTAL    3
`define PIO_STRAP_CYC     (`PIO_STRAP_XTAL)
`define PIO_FETCH_HALVES  13
`define PIO_FETCH_CYC     ((`PIO_FETCH_HALVES + 1) / 2)

`endif

// ---- inc/pio_pkg.sv ----
// types of the programmable pin configuration block
package pio_pkg;

  // *************************************************************
  // sequencer states
  // *************************************************************
  typedef enum logic [3:0] {
    PIO_ST_HOLD  = 4'h1,
    PIO_ST_STRAP = 4'h2,
    PIO_ST_FETCH = 4'h4,
    PIO_ST_RUN   = 4'h8
  } pio_fsm_t;

  // *************************************************************
  // state of the synchroniser
  // *************************************************************
  typedef struct packed {
    logic meta;
    logic sync;
  } pio_sync_t;

  // *************************************************************
  // state of the main block
  // *************************************************************
  typedef struct packed {
    pio_fsm_t    fsm;
    logic [3:0]  cnt;
    logic [15:0] low_cnt;
    logic        strap_low;
    logic        short_rst;
    logic        fetch_start;
    logic [31:0] mode;
    logic [31:0] dir;
    logic [31:0] pull;
    logic [31:0] dout;
    logic [15:0] lsel;
    logic [15:0] usel;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pu;
    logic [31:0] pd;
    logic [31:0] func_in;
    logic [1:0]  addr_off;
  } pio_state_t;

endpackage : pio_pkg

// ---- design/pio_reset_sync.sv ----
// reset input synchroniser of the pin configuration block
`timescale 1ns/1ps
`default_nettype none

module pio_reset_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic reset_input_n,
  output var  logic reset_sync_n
);

  pio_pkg::pio_sync_t s;
  pio_pkg::pio_sync_t next_s;
  logic               arst_n;

  // assertion is immediate, release is clocked
  assign arst_n = presetn & reset_input_n;

  always_comb begin
    next_s.meta = 1'b1;
    next_s.sync = s.meta;
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reset_sync_n = s.sync;

endmodule : pio_reset_sync

`default_nettype wire

// ---- design/pio_config.sv ----
// programmable pin configuration with strap and reset sequencing
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"

module pio_config #(
  parameter int unsigned RESET_MIN_CYCLES = `PIO_RESET_MIN_CYC
) (
  // ***************************************************************
  // register bus
  // ***************************************************************
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // ***************************************************************
  // reset input and strap
  // ***************************************************************
  input  wire logic        reset_input_n,
  input  wire logic        address_enable_strap,
  // ***************************************************************
  // pads
  // ***************************************************************
  input  wire logic [31:0] pin_in,
  output var  logic [31:0] pin_out,
  output var  logic [31:0] pin_oe,
  output var  logic [31:0] pull_up_en,
  output var  logic [31:0] pull_dn_en,
  // ***************************************************************
  // peripheral side
  // ***************************************************************
  input  wire logic [31:0] func_out,
  input  wire logic [31:0] func_oe,
  output var  logic [31:0] func_in,
  // ***************************************************************
  // start-up sequencing
  // ***************************************************************
  output var  logic        internal_reset_n,
  output var  logic        fetch_start,
  output var  logic [19:0] restart_address,
  output var  logic        lower_addr_off,
  output var  logic        upper_addr_off
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic addr_known(input logic [11:0] a);
    unique case (a)
      `PIO_OFS_MODE,
      `PIO_OFS_DIR,
      `PIO_OFS_PULL,
      `PIO_OFS_DOUT,
      `PIO_OFS_PIN_IN,
      `PIO_OFS_LOWER_SEL,
      `PIO_OFS_UPPER_SEL,
      `PIO_OFS_STATUS: addr_known = 1'b1;
      default:         addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // ***************************************************************
  // field rules
  // ***************************************************************
  // fixed-pull pins hold their only legal setting
  function automatic logic [31:0] fix_pull(input logic [31:0] p);
    fix_pull = (p | `PIO_PULLUP_ONLY) & ~`PIO_PULLDN_ONLY;
  endfunction : fix_pull

  // locked pins never become general pins
  function automatic logic [31:0] lock_mode(input logic [31:0] m,
                                            input logic        lk);
    lock_mode = lk ? (m & ~`PIO_STRAP_LOCK) : m;
  endfunction : lock_mode

  // disable-address bit is void when the strap was low
  function automatic logic [15:0] sel_write(input logic [15:0] w,
                                            input logic [15:0] old,
                                            input logic        lk);
    logic [15:0] r;
    r = w;
    if (lk) begin
      r[`PIO_DA_BIT] = old[`PIO_DA_BIT];
    end
    sel_write = r;
  endfunction : sel_write

  // general pins drive from the settings, others from the peripheral
  function automatic logic [31:0] drive_sel(input logic [31:0] g,
                                            input logic [31:0] own,
                                            input logic [31:0] periph);
    drive_sel = (g & own) | (~g & periph);
  endfunction : drive_sel

  // pulls only on general inputs; fixed-pull pins keep their one pull
  function automatic logic [31:0] pull_up_of(input logic [31:0] in_pins,
                                             input logic [31:0] p);
    pull_up_of = in_pins & (`PIO_PULLUP_ONLY
                 | (~`PIO_PULLDN_ONLY & p));
  endfunction : pull_up_of

  function automatic logic [31:0] pull_dn_of(input logic [31:0] in_pins,
                                             input logic [31:0] p);
    pull_dn_of = in_pins & (`PIO_PULLDN_ONLY
                 | (~`PIO_PULLUP_ONLY & ~p));
  endfunction : pull_dn_of

  function automatic logic [31:0] status_word(input logic strap_low,
                                              input logic short_rst,
                                              input logic running);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[`PIO_ST_STRAP_LOW] = strap_low;
    w[`PIO_ST_SHORT_RST] = short_rst;
    w[`PIO_ST_RUNNING]   = running;
    status_word = w;
  endfunction : status_word

  // saturating, so a long reset never wraps to look short
  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc16

  // ***************************************************************
  // reset input synchroniser
  // ***************************************************************
  logic rst_sync_n;

  pio_reset_sync u_reset_sync (
    .pclk          (pclk),
    .presetn       (presetn),
    .reset_input_n (reset_input_n),
    .reset_sync_n  (rst_sync_n)
  );

  // ***************************************************************
  // state
  // ***************************************************************
  pio_pkg::pio_state_t s;
  pio_pkg::pio_state_t next_s;
  logic [31:0]         gp;
  logic [31:0]         gp_in;
  logic                acc_wr;
  logic                setup;
  logic [31:0]         rd_word;
  logic [31:0]         status;

  assign gp    = lock_mode(s.mode, s.strap_low);
  assign gp_in = gp & ~s.dir;
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & addr_known(paddr)
                  & (s.fsm != pio_pkg::PIO_ST_HOLD);

  assign status = status_word(s.strap_low, s.short_rst,
                              s.fsm == pio_pkg::PIO_ST_RUN);

  always_comb begin
    unique case (paddr)
      `PIO_OFS_MODE:      rd_word = s.mode;
      `PIO_OFS_DIR:       rd_word = s.dir;
      `PIO_OFS_PULL:      rd_word = s.pull;
      `PIO_OFS_DOUT:      rd_word = s.dout;
      `PIO_OFS_PIN_IN:    rd_word = pin_in;
      `PIO_OFS_LOWER_SEL: rd_word = {16'h0000, s.lsel};
      `PIO_OFS_UPPER_SEL: rd_word = {16'h0000, s.usel};
      `PIO_OFS_STATUS:    rd_word = status;
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_s             = s;
    next_s.fetch_start = 1'b0;

    // ***********************************************************
    // sequencer after the reset input is released
    // ***********************************************************
    unique case (s.fsm)
      pio_pkg::PIO_ST_HOLD: begin
        next_s.fsm       = pio_pkg::PIO_ST_STRAP;
        next_s.cnt       = 4'h1;
        next_s.short_rst = (s.low_cnt < 16'(RESET_MIN_CYCLES));
      end
      pio_pkg::PIO_ST_STRAP: begin
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt == 4'(`PIO_STRAP_CYC - 1)) begin
          next_s.strap_low = ~address_enable_strap;
          next_s.mode = lock_mode(s.mode, ~address_enable_strap);
          if (!address_enable_strap) begin
            next_s.lsel[`PIO_DA_BIT] = 1'b0;
            next_s.usel[`PIO_DA_BIT] = 1'b0;
          end
          next_s.fsm = pio_pkg::PIO_ST_FETCH;
        end
      end
      pio_pkg::PIO_ST_FETCH: begin
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt == 4'(`PIO_FETCH_CYC - 1)) begin
          next_s.fetch_start = 1'b1;
          next_s.fsm         = pio_pkg::PIO_ST_RUN;
        end
      end
      pio_pkg::PIO_ST_RUN: begin
        next_s.cnt = s.cnt;
      end
      default: begin
        next_s.fsm = pio_pkg::PIO_ST_HOLD;
      end
    endcase

    // ***********************************************************
    // register writes take effect at the access edge
    // ***********************************************************
    if (acc_wr) begin
      unique case (paddr)
        `PIO_OFS_MODE: begin
          next_s.mode = lock_mode(pwdata, s.strap_low);
        end
        `PIO_OFS_DIR: begin
          next_s.dir = pwdata;
        end
        `PIO_OFS_PULL: begin
          next_s.pull = fix_pull(pwdata);
        end
        `PIO_OFS_DOUT: begin
          next_s.dout = pwdata;
        end
        `PIO_OFS_LOWER_SEL: begin
          next_s.lsel = sel_write(pwdata[15:0], s.lsel, s.strap_low);
        end
        `PIO_OFS_UPPER_SEL: begin
          next_s.usel = sel_write(pwdata[15:0], s.usel, s.strap_low);
        end
        default: begin
          next_s.dout = s.dout;
        end
      endcase
    end

    // ***********************************************************
    // read data settles in setup so the access needs no wait
    // ***********************************************************
    if (setup) begin
      next_s.prdata  = rd_word;
      next_s.pslverr = ~addr_known(paddr);
    end else if (!psel) begin
      next_s.pslverr = 1'b0;
    end

    // ***********************************************************
    // pad drive
    // ***********************************************************
    next_s.pin_oe  = drive_sel(gp, s.dir, func_oe);
    next_s.pin_out = drive_sel(gp, s.dout, func_out);
    next_s.pu      = pull_up_of(gp_in, s.pull);
    next_s.pd      = pull_dn_of(gp_in, s.pull);
    // a general pin feeds its peripheral low, so ready reads inactive
    next_s.func_in  = ~gp & pin_in;
    next_s.addr_off = {~s.strap_low & s.usel[`PIO_DA_BIT],
                       ~s.strap_low & s.lsel[`PIO_DA_BIT]};

    // ***********************************************************
    // reset input low: abort and clear, keep only strap and length
    // ***********************************************************
    if (!rst_sync_n) begin
      next_s.fsm         = pio_pkg::PIO_ST_HOLD;
      next_s.cnt         = 4'h0;
      next_s.fetch_start = 1'b0;
      next_s.mode        = `PIO_MODE_RST;
      next_s.dir         = `PIO_DIR_RST;
      next_s.pull        = `PIO_PULL_RST;
      next_s.dout        = `PIO_DOUT_RST;
      next_s.lsel        = `PIO_SEL_RST;
      next_s.usel        = `PIO_SEL_RST;
      if (s.fsm != pio_pkg::PIO_ST_HOLD) begin
        next_s.low_cnt = 16'h0001;
      end else begin
        next_s.low_cnt = sat_inc16(s.low_cnt);
      end
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.fsm       <= pio_pkg::PIO_ST_HOLD;
      s.mode      <= `PIO_MODE_RST;
      s.dir       <= `PIO_DIR_RST;
      s.pull      <= `PIO_PULL_RST;
      s.dout      <= `PIO_DOUT_RST;
      s.lsel      <= `PIO_SEL_RST;
      s.usel      <= `PIO_SEL_RST;
      s.pu        <= `PIO_MODE_RST & `PIO_PULL_RST;
      s.pd        <= `PIO_MODE_RST & ~`PIO_PULL_RST;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign prdata           = s.prdata;
  assign pready           = 1'b1;
  assign pslverr          = s.pslverr & psel & penable;
  assign pin_out          = s.pin_out;
  assign pin_oe           = s.pin_oe;
  assign pull_up_en       = s.pu;
  assign pull_dn_en       = s.pd;
  assign func_in          = s.func_in;
  assign internal_reset_n = rst_sync_n;
  assign fetch_start      = s.fetch_start;
  assign restart_address  = `PIO_RESTART_ADDR;
  assign lower_addr_off   = s.addr_off[0];
  assign upper_addr_off   = s.addr_off[1];

endmodule : pio_config

`default_nettype wire

// ---- verification/pio_config_monitor.sv ----
// assertion checker of the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module pio_config_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        reset_input_n,
  input wire logic        address_enable_strap,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pull_up_en,
  input wire logic [31:0] pull_dn_en,
  input wire logic [31:0] func_oe,
  input wire logic        internal_reset_n,
  input wire logic        fetch_start,
  input wire logic        lower_addr_off,
  input wire logic        upper_addr_off
);
  // ****
  // helper: cycles since release, strap copy
  // ****
  logic [3:0] run_cnt;
  logic       lock_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= 4'h0;
      lock_q  <= 1'b0;
    end else begin
      if (!internal_reset_n)
        run_cnt <= 4'h0;
      else if (run_cnt != 4'hF)
        run_cnt <= run_cnt + 4'h1;
      if (internal_reset_n && run_cnt == 4'h2)
        lock_q <= !address_enable_strap;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_release;
    $rose(internal_reset_n);
  endsequence
  sequence s_fetch;
    !fetch_start [*7] ##1 fetch_start ##1 !fetch_start;
  endsequence
  fetch_delay_a: assert property (s_release |-> s_fetch)
    else $error("fetch start off time");
  abort_fetch_a: assert property (!internal_reset_n |-> !fetch_start)
    else $error("fetch during reset");
  sync_reset_a: assert property (!reset_input_n |=> !internal_reset_n)
    else $error("reset not taken");
  default_pull_a: assert property (s_release |->
    (pull_up_en & 32'hDBFF_FFFF) == 32'hDB3F_F80D &&
    (pull_dn_en & 32'hDBFF_FFFF) == 32'h00C0_0402)
    else $error("pull defaults wrong");
  default_drive_a: assert property (s_release |->
    (pin_oe & 32'hDBFF_FFFF) == (func_oe & 32'h0000_03F0))
    else $error("drive defaults wrong");
  strap_lock_a: assert property (lock_q && run_cnt == 4'hF |->
    pin_oe[29] == func_oe[29] && pin_oe[26] == func_oe[26])
    else $error("locked pin reassigned");
  addr_mux_a: assert property (lock_q && run_cnt == 4'hF |->
    !lower_addr_off && !upper_addr_off)
    else $error("muxed bus off with strap low");
  err_phase_a: assert property (pslverr |->
    psel && penable && (paddr > 12'h01C || paddr[1:0] != 2'b00))
    else $error("error outside access");
  unmapped_err_a: assert property (psel && penable &&
    (paddr > 12'h01C || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
endmodule : pio_config_monitor
bind pio_config pio_config_monitor u_mon (.pclk, .presetn, .paddr, .psel,
  .penable, .pslverr, .reset_input_n, .address_enable_strap, .pin_oe,
  .pull_up_en, .pull_dn_en, .func_oe, .internal_reset_n, .fetch_start,
  .lower_addr_off, .upper_addr_off);
`default_nettype wire

// ---- verification/pio_board_model.sv ----
// board model: pad level of each shared pin
`timescale 1ns/1ps
`default_nettype none
module pio_board_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pull_up_en,
  input  wire logic [31:0] pull_dn_en,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output var  logic [31:0] pin_in
);
  logic [31:0] last_q;
  logic [31:0] ext_ok;
  // board lets go of pin 29 while reset is held
  assign ext_ok = presetn ? ext_en : ext_en & 32'hDFFF_FFFF;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_q <= 32'h0;
    else
      last_q <= pin_in;
  end
  // floating pad flips, so no stale level is read
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_ok[i])
        pin_in[i] = ext_val[i];
      else if (pull_up_en[i] || pull_dn_en[i])
        pin_in[i] = pull_up_en[i];
      else
        pin_in[i] = ~last_q[i];
    end
  end
endmodule : pio_board_model
`default_nettype wire

// ---- verification/programmable_io_pin_config_test.sv ----
// self-checking bench of the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module programmable_io_pin_config_test;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } pio_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        reset_input_n, address_enable_strap, internal_reset_n;
  logic        fetch_start, lower_addr_off, upper_addr_off;
  logic [11:0] paddr;
  logic [19:0] restart_address;
  logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pull_up_en;
  logic [31:0] pull_dn_en, func_out, func_oe, func_in, ext_en, ext_val;
  int          err_count, cmp_count;
  // reset values, then start-up reconfiguration, then a refused unmapped write
  pio_row_t    rows [11] = '{
    '{1'b0, 12'h000, 32'h0, 32'hFFFF_FC0F, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'hFF3F_FBBD, 1'b0},
    '{1'b0, 12'h014, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h014, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0},
    '{1'b1, 12'h000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0},
    '{1'b1, 12'h004, 32'hA5A5_A5A5, 32'hA5A5_A5A5, 1'b0},
    '{1'b1, 12'h008, 32'h0, 32'h0000_03B0, 1'b0},
    '{1'b1, 12'h008, 32'hFFFF_FFFF, 32'hFFFF_FFBF, 1'b0},
    '{1'b1, 12'h00C, 32'h1234_5678, 32'h1234_5678, 1'b0},
    '{1'b1, 12'h020, 32'h1, 32'h0, 1'b1}};
  pio_config #(.RESET_MIN_CYCLES(20)) dut (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .reset_input_n, .address_enable_strap, .pin_in, .pin_out, .pin_oe,
    .pull_up_en, .pull_dn_en, .func_out, .func_oe, .func_in,
    .internal_reset_n, .fetch_start, .restart_address, .lower_addr_off,
    .upper_addr_off);
  pio_board_model u_board (.pclk, .presetn, .pin_out, .pin_oe,
    .pull_up_en, .pull_dn_en, .ext_en, .ext_val, .pin_in);
  task summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] got, x);
    cmp_count++;
    if (got !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, x, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", q, x);
  endtask : rdchk
  // bounded wait for the start of fetch
  task automatic wait_fetch;
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      summarize();
    end
  endtask : wait_fetch
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    logic [31:0] rd;
    logic        er;
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, ext_en, ext_val} = 108'h0;
    reset_input_n = 1'b1;
    address_enable_strap = 1'b1;
    func_oe = 32'h0F0F_0F0F;
    func_out = 32'h3C3C_3C3C;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_fetch();
    for (int i = 0; i < 11; i++) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0, rd, er);
      chk("prdata", rd, rows[i].q);
      chk("pslverr", {31'h0, er}, {31'h0, rows[i].e});
    end
    ext_en <= 32'hFFFF_0000;
    repeat (4) @(posedge pclk);
    chk("pin_oe", pin_oe, 32'hA5A5_A5A5);
    chk("pull_up", pull_up_en, 32'h5A5A_5A1A);
    chk("pull_dn", pull_dn_en, 32'h0000_0040);
    chk("pin_out", pin_out & pin_oe, 32'h0024_0420);
    chk("lower_off", {31'h0, lower_addr_off}, 32'h1);
    chk("func_in", func_in, 32'h0);
    chk("restart", {12'h0, restart_address}, 32'h000F_FFF0);
    rdchk(12'h010, 32'h0024_5E3A);
    wr(12'h000, 32'h0);
    repeat (3) @(posedge pclk);
    chk("pin_oe", pin_oe, func_oe);
    chk("pulls", pull_up_en | pull_dn_en, 32'h0);
    chk("pin_out", pin_out & func_oe, func_out & func_oe);
    chk("func_in", func_in & 32'hFFFF_0F0F, 32'h0C0C_0C0C);
    // short reset with the strap low; a write while held is lost
    ext_en <= 32'h0;
    address_enable_strap <= 1'b0;
    reset_input_n <= 1'b0;
    wr(12'h000, 32'hFFFF_FFFF);
    repeat (8) @(posedge pclk);
    reset_input_n <= 1'b1;
    wait_fetch();
    rdchk(12'h01C, 32'h7);
    rdchk(12'h000, 32'hDBFF_FC0F);
    wr(12'h000, 32'hFFFF_FFFF);
    rdchk(12'h000, 32'hDBFF_FFFF);
    wr(12'h004, 32'hFFFF_FFFF);
    wr(12'h014, 32'h0000_0080);
    rdchk(12'h014, 32'h0);
    address_enable_strap <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("lower_off", {31'h0, lower_addr_off}, 32'h0);
    rdchk(12'h01C, 32'h7);
    reset_input_n <= 1'b0;
    repeat (25) @(posedge pclk);
    reset_input_n <= 1'b1;
    wait_fetch();
    rdchk(12'h01C, 32'h4);
    wr(12'h018, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    chk("upper_off", {31'h0, upper_addr_off}, 32'h1);
    summarize();
  end
endmodule : programmable_io_pin_config_test
`default_nettype wire
